// ===== include/anrls_map.vh
// Overview of operation
// - local high swing request bit, stored without capability check
// - capture partner high swing offer and request
// - low swing unless both offer and one requests
// - high swing when both offer, one requests
// - local role forced versus preferred bit
// - local role bit: zero slave, one master
// - capture partner forced and role bits
// - equal preferred roles settled by random bit
// - forced side wins over preferred side
// - both forced same role: fault, link down
// - differing roles: each takes its own
// - readable role result: slave, master, fault
// - exchange done flag at exchange end
// - finished flag only when done and up
// - latch-low link status, software reads twice
// - link drop restarts negotiation automatically
// - software restart bit in control register
// - undriven strap gives preferred slave
// - local offer bit: both levels or low only
// - strap sets default preferred role
`ifndef ANRLS_MAP_VH
`define ANRLS_MAP_VH

// register byte offsets
`define ANRLS_OFS_CONTROL  8'h00
`define ANRLS_OFS_STATUS   8'h04
`define ANRLS_OFS_LOCAL    8'h08
`define ANRLS_OFS_PARTNER  8'h0c
`define ANRLS_OFS_RESULT   8'h10

// control fields
`define ANRLS_CTL_RESTART  9

// status fields
`define ANRLS_ST_CAPABLE   0
`define ANRLS_ST_LINK      2
`define ANRLS_ST_FINISHED  5
`define ANRLS_ST_DONE      6

// advertisement word fields, same layout local and partner
`define ANRLS_ADV_FORCED   0
`define ANRLS_ADV_MASTER   1
`define ANRLS_ADV_OFFER    2
`define ANRLS_ADV_REQUEST  3

// result fields
`define ANRLS_RES_ROLE_LO  0
`define ANRLS_RES_ROLE_HI  1
`define ANRLS_RES_HIGH     2

// role result encodings
`define ANRLS_ROLE_SLAVE   2'h0
`define ANRLS_ROLE_MASTER  2'h1
`define ANRLS_ROLE_FAULT   2'h2

// reset values
`define ANRLS_RST_FORCED   1'b0
`define ANRLS_RST_REQUEST  1'b0
`define ANRLS_LFSR_SEED    16'hace1

`endif

// ===== design/anrls_lfsr.v
`timescale 1ns/1ps
`default_nettype none
`include "anrls_map.vh"

module anrls_lfsr (
  // clock and reset
  input  wire clk,
  input  wire rstn,
  // random bit
  output wire randomBit
);

  reg [15:0] shiftState;

  // free running maximal length sequence
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shiftState <= `ANRLS_LFSR_SEED;
    end else begin
      shiftState <= {shiftState[14:0],
                     shiftState[15] ^ shiftState[13] ^ shiftState[12] ^ shiftState[10]};
    end
  end

  assign randomBit = shiftState[15];

endmodule // anrls_lfsr
`default_nettype wire

// ===== design/anrls_resolver.v
`timescale 1ns/1ps
`default_nettype none
`include "anrls_map.vh"

module anrls_resolver (
  // local advertisement
  input  wire       localForced,
  input  wire       localMaster,
  input  wire       localOffer,
  input  wire       localRequest,
  // partner advertisement
  input  wire       partnerForced,
  input  wire       partnerMaster,
  input  wire       partnerOffer,
  input  wire       partnerRequest,
  // tie breaker
  input  wire       randomBit,
  // resolution
  output wire       highSwing,
  output reg  [1:0] roleResult
);

  // both able and at least one asks, otherwise low swing
  assign highSwing = localOffer & partnerOffer & (localRequest | partnerRequest);

  // role table
  always @* begin
    roleResult = `ANRLS_ROLE_SLAVE;
    if (localForced && partnerForced) begin
      if (localMaster == partnerMaster) begin
        roleResult = `ANRLS_ROLE_FAULT;
      end else begin
        roleResult = localMaster ? `ANRLS_ROLE_MASTER : `ANRLS_ROLE_SLAVE;
      end
    end else if (localForced) begin
      roleResult = localMaster ? `ANRLS_ROLE_MASTER : `ANRLS_ROLE_SLAVE;
    end else if (partnerForced) begin
      roleResult = partnerMaster ? `ANRLS_ROLE_SLAVE : `ANRLS_ROLE_MASTER;
    end else if (localMaster != partnerMaster) begin
      roleResult = localMaster ? `ANRLS_ROLE_MASTER : `ANRLS_ROLE_SLAVE;
    end else begin
      roleResult = randomBit ? `ANRLS_ROLE_MASTER : `ANRLS_ROLE_SLAVE;
    end
  end

endmodule // anrls_resolver
`default_nettype wire

// ===== design/anrls_autoneg.v
`timescale 1ns/1ps
`default_nettype none
`include "anrls_map.vh"

module anrls_autoneg (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // straps and capability
  input  wire        roleSelectStrap,
  input  wire        highSwingCapable,
  // partner page from the line exchange
  input  wire        partnerPageValid,
  input  wire        partnerRoleForcedIn,
  input  wire        partnerRoleMasterIn,
  input  wire        partnerHighSwingOfferIn,
  input  wire        partnerHighSwingRequestIn,
  // link from the data path
  input  wire        linkUp,
  // towards the line exchange and data path
  output reg         negotiationStart,
  output wire        linkEnable,
  output reg         selectedHighSwing,
  output reg         selectedMaster,
  output wire        configFault
);

  // negotiation states
  localparam [2:0] ST_INIT     = 3'h0;
  localparam [2:0] ST_EXCHANGE = 3'h1;
  localparam [2:0] ST_LINKWAIT = 3'h2;
  localparam [2:0] ST_LINKUP   = 3'h3;
  localparam [2:0] ST_FAULT    = 3'h4;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg         strapLoaded;
  reg         localRoleForced;
  reg         localRoleMaster;
  reg         localHighSwingOffer;
  reg         localHighSwingRequest;
  reg         partnerRoleForced;
  reg         partnerRoleMaster;
  reg         partnerHighSwingOffer;
  reg         partnerHighSwingRequest;
  reg  [1:0]  roleResolutionResult;
  reg         latchedLinkUp;
  reg         next_latchedLinkUp;
  reg  [31:0] next_prdata;
  reg         next_pslverr;
  wire        setupPhase;
  wire        accessPhase;
  wire        writeAccess;
  wire        readAccess;
  wire        addrMapped;
  wire        restartWrite;
  wire        linkDrop;
  wire        restartAny;
  wire        pageTaken;
  wire        randomBit;
  wire        resolvedHigh;
  wire [1:0]  resolvedRole;
  wire        negotiationExchangeDone;
  wire        negotiationFinishedFlag;
  // register selects, decoded accesses and assembled read words
  wire        controlHit;
  wire        statusHit;
  wire        localHit;
  wire        partnerHit;
  wire        resultHit;
  wire        controlWrite;
  wire        localWrite;
  wire        statusRead;
  wire        pageFault;
  wire        resultMaster;
  reg  [31:0] statusWord;
  reg  [31:0] localWord;
  reg  [31:0] partnerWord;
  reg  [31:0] resultWord;

  // random source for role ties
  anrls_lfsr anrls_lfsr_inst (
    .clk       (clk),
    .rstn      (rstn),
    .randomBit (randomBit)
  );

  // resolution from the captured words, partner bits taken live on the page
  anrls_resolver anrls_resolver_inst (
    .localForced    (localRoleForced),
    .localMaster    (localRoleMaster),
    .localOffer     (localHighSwingOffer),
    .localRequest   (localHighSwingRequest),
    .partnerForced  (partnerRoleForcedIn),
    .partnerMaster  (partnerRoleMasterIn),
    .partnerOffer   (partnerHighSwingOfferIn),
    .partnerRequest (partnerHighSwingRequestIn),
    .randomBit      (randomBit),
    .highSwing      (resolvedHigh),
    .roleResult     (resolvedRole)
  );

  // apb phase decode, zero wait state slave
  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign pready      = 1'b1;
  assign writeAccess = accessPhase & pwrite;
  assign readAccess  = accessPhase & ~pwrite;
  assign addrMapped  = controlHit | statusHit | localHit | partnerHit | resultHit;

  // register selects from the byte address, then the accesses that act on them
  assign controlHit   = (paddr == `ANRLS_OFS_CONTROL);
  assign statusHit    = (paddr == `ANRLS_OFS_STATUS);
  assign localHit     = (paddr == `ANRLS_OFS_LOCAL);
  assign partnerHit   = (paddr == `ANRLS_OFS_PARTNER);
  assign resultHit    = (paddr == `ANRLS_OFS_RESULT);
  assign controlWrite = writeAccess & controlHit & pstrb[1];
  assign localWrite   = writeAccess & localHit & pstrb[0];
  assign statusRead   = readAccess & statusHit;

  // restart sources
  assign restartWrite = controlWrite & pwdata[`ANRLS_CTL_RESTART];
  assign linkDrop     = (state == ST_LINKUP) & ~linkUp;
  assign restartAny   = strapLoaded & (restartWrite | linkDrop);
  assign pageTaken    = (state == ST_EXCHANGE) & partnerPageValid & ~restartAny;

  // flags derived from state, link and the role resolution
  assign negotiationExchangeDone = (state == ST_LINKWAIT) | (state == ST_LINKUP);
  assign negotiationFinishedFlag = (state == ST_LINKUP) & linkUp;
  assign linkEnable              = negotiationExchangeDone;
  assign configFault             = (roleResolutionResult == `ANRLS_ROLE_FAULT);
  assign pageFault               = (resolvedRole == `ANRLS_ROLE_FAULT);
  assign resultMaster            = (resolvedRole == `ANRLS_ROLE_MASTER);

  // next state of the negotiation
  always @* begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (strapLoaded) begin
          next_state = ST_EXCHANGE;
        end
      end
      ST_EXCHANGE: begin
        if (pageTaken) begin
          if (pageFault) begin
            next_state = ST_FAULT;
          end else begin
            next_state = ST_LINKWAIT;
          end
        end
      end
      ST_LINKWAIT: begin
        if (linkUp) begin
          next_state = ST_LINKUP;
        end
      end
      ST_LINKUP: begin
        if (!linkUp) begin
          next_state = ST_EXCHANGE;
        end
      end
      ST_FAULT: begin
        next_state = ST_FAULT;
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
    if (restartAny) begin
      next_state = ST_EXCHANGE;
    end
  end

  // negotiation state register
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // one cycle start pulse towards the line exchange, the first one after the strap load
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      negotiationStart <= 1'b0;
    end else begin
      negotiationStart <= restartAny | ((state == ST_INIT) & strapLoaded);
    end
  end

  // local advertisement: defaults caught after reset, then software owned
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strapLoaded           <= 1'b0;
      localRoleForced       <= `ANRLS_RST_FORCED;
      localRoleMaster       <= 1'b0;
      localHighSwingOffer   <= 1'b0;
      localHighSwingRequest <= `ANRLS_RST_REQUEST;
    end else if (!strapLoaded) begin
      strapLoaded         <= 1'b1;
      localRoleMaster     <= roleSelectStrap;
      localHighSwingOffer <= highSwingCapable;
    end else if (localWrite) begin
      localRoleForced       <= pwdata[`ANRLS_ADV_FORCED];
      localRoleMaster       <= pwdata[`ANRLS_ADV_MASTER];
      localHighSwingOffer   <= pwdata[`ANRLS_ADV_OFFER] & highSwingCapable;
      localHighSwingRequest <= pwdata[`ANRLS_ADV_REQUEST];
    end
  end

  // partner capture on the accepted page
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      partnerRoleForced       <= 1'b0;
      partnerRoleMaster       <= 1'b0;
      partnerHighSwingOffer   <= 1'b0;
      partnerHighSwingRequest <= 1'b0;
    end else if (pageTaken) begin
      partnerRoleForced       <= partnerRoleForcedIn;
      partnerRoleMaster       <= partnerRoleMasterIn;
      partnerHighSwingOffer   <= partnerHighSwingOfferIn;
      partnerHighSwingRequest <= partnerHighSwingRequestIn;
    end
  end

  // resolution results, held until the next accepted page
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      roleResolutionResult <= `ANRLS_ROLE_SLAVE;
      selectedHighSwing    <= 1'b0;
      selectedMaster       <= 1'b0;
    end else if (pageTaken) begin
      roleResolutionResult <= resolvedRole;
      selectedHighSwing    <= resolvedHigh & localHighSwingOffer;
      selectedMaster       <= resultMaster;
    end
  end

  // latch low link status: the reload of a read wins over a latched failure
  always @* begin
    next_latchedLinkUp = latchedLinkUp & linkUp;
    if (statusRead) begin
      next_latchedLinkUp = linkUp;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latchedLinkUp <= 1'b0;
    end else begin
      latchedLinkUp <= next_latchedLinkUp;
    end
  end

  // status word: capability, latched link, finished and done flags
  always @* begin
    statusWord                     = 32'h0000_0000;
    statusWord[`ANRLS_ST_CAPABLE]  = highSwingCapable;
    statusWord[`ANRLS_ST_LINK]     = latchedLinkUp;
    statusWord[`ANRLS_ST_FINISHED] = negotiationFinishedFlag;
    statusWord[`ANRLS_ST_DONE]     = negotiationExchangeDone;
  end

  // local advertisement word as it is offered on the line
  always @* begin
    localWord                     = 32'h0000_0000;
    localWord[`ANRLS_ADV_FORCED]  = localRoleForced;
    localWord[`ANRLS_ADV_MASTER]  = localRoleMaster;
    localWord[`ANRLS_ADV_OFFER]   = localHighSwingOffer;
    localWord[`ANRLS_ADV_REQUEST] = localHighSwingRequest;
  end

  // partner advertisement word, same field layout
  always @* begin
    partnerWord                     = 32'h0000_0000;
    partnerWord[`ANRLS_ADV_FORCED]  = partnerRoleForced;
    partnerWord[`ANRLS_ADV_MASTER]  = partnerRoleMaster;
    partnerWord[`ANRLS_ADV_OFFER]   = partnerHighSwingOffer;
    partnerWord[`ANRLS_ADV_REQUEST] = partnerHighSwingRequest;
  end

  // result word: role code and selected level
  always @* begin
    resultWord                                        = 32'h0000_0000;
    resultWord[`ANRLS_RES_ROLE_HI:`ANRLS_RES_ROLE_LO] = roleResolutionResult;
    resultWord[`ANRLS_RES_HIGH]                       = selectedHighSwing;
  end

  // read data prepared in the setup phase; writes and unmapped addresses read zero
  always @* begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = ~addrMapped;
    case (paddr)
      `ANRLS_OFS_CONTROL: begin
        next_prdata = 32'h0000_0000; // restart reads back as zero
      end
      `ANRLS_OFS_STATUS: begin
        next_prdata = statusWord;
      end
      `ANRLS_OFS_LOCAL: begin
        next_prdata = localWord;
      end
      `ANRLS_OFS_PARTNER: begin
        next_prdata = partnerWord;
      end
      `ANRLS_OFS_RESULT: begin
        next_prdata = resultWord;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
    if (pwrite) begin
      next_prdata = 32'h0000_0000;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule // anrls_autoneg
`default_nettype wire

// ===== tb/anrls_autoneg_properties.sv
`timescale 1ns/1ps
`default_nettype none
module anrls_autoneg_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // inputs seen by the block
  input wire logic highSwingCapable,
  input wire logic partnerPageValid,
  input wire logic partnerRoleForcedIn,
  input wire logic partnerRoleMasterIn,
  input wire logic partnerHighSwingOfferIn,
  input wire logic linkUp,
  // block outputs
  input wire logic negotiationStart,
  input wire logic linkEnable,
  input wire logic selectedHighSwing,
  input wire logic selectedMaster,
  input wire logic configFault
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // level picked at the page that enables the link
  AST_LOW_NO_OFFER: assert property (
    $rose(linkEnable) && !$past(partnerHighSwingOfferIn) |-> !selectedHighSwing)
    else $error("high level without partner offer");
  AST_LOW_NO_CAP: assert property (
    $rose(linkEnable) && !$past(highSwingCapable) |-> !selectedHighSwing)
    else $error("high level without local capability");
  // a forced partner role wins
  AST_FORCED_MASTER: assert property (
    $rose(linkEnable) && $past(partnerRoleForcedIn && partnerRoleMasterIn) |-> !selectedMaster)
    else $error("master against forced partner master");
  AST_FORCED_SLAVE: assert property (
    $rose(linkEnable) && $past(partnerRoleForcedIn && !partnerRoleMasterIn) |-> selectedMaster)
    else $error("slave against forced partner slave");
  // a fault keeps the link off and needs a forced partner
  AST_FAULT_DOWN: assert property (configFault |-> !linkEnable)
    else $error("link enabled in fault");
  AST_FAULT_CAUSE: assert property (
    $rose(configFault) |-> $past(partnerPageValid && partnerRoleForcedIn))
    else $error("fault without forced partner page");
  // every page after a start ends the exchange
  AST_EXCHANGE_DONE: assert property (
    negotiationStart ##[1:20] partnerPageValid |=> linkEnable || configFault)
    else $error("page did not end the exchange");
  // losing an established link starts a new exchange
  AST_AUTO_RESTART: assert property (
    linkEnable && $past(linkEnable && linkUp) && !linkUp |=> negotiationStart && !linkEnable)
    else $error("no restart after link loss");
  // results hold while the link is enabled
  AST_RESULT_HOLD: assert property (
    linkEnable && $past(linkEnable) |-> $stable(selectedMaster) && $stable(selectedHighSwing))
    else $error("result changed while linked");
endmodule // anrls_autoneg_checker

bind anrls_autoneg anrls_autoneg_checker anrls_autoneg_checker_inst (
  .clk, .rstn, .highSwingCapable, .partnerPageValid, .partnerRoleForcedIn,
  .partnerRoleMasterIn, .partnerHighSwingOfferIn, .linkUp, .negotiationStart,
  .linkEnable, .selectedHighSwing, .selectedMaster, .configFault
);
`default_nettype wire

// ===== tb/anrls_partner.sv
`timescale 1ns/1ps
`default_nettype none
module anrls_partner (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // local device side
  input  wire logic       negotiationStart,
  input  wire logic       linkEnable,
  // scenario control, advert laid out as forced, master, offer, request
  input  wire logic [3:0] advert,
  input  wire logic       slow,
  input  wire logic       linkOk,
  // page and link towards the device
  output var  logic       pageValid,
  output var  logic [3:0] pageBits,
  output var  logic       linkUp
);
  logic [3:0] waitCnt;
  logic       pending;

  // one page per start, after a short or a long exchange
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending <= 1'b0;
      waitCnt <= 4'h0;
      pageValid <= 1'b0;
      pageBits <= 4'h0;
      linkUp <= 1'b0;
    end else begin
      pageValid <= 1'b0;
      pageBits <= ~pageBits;          // bits invert every cycle, advert only on the page cycle
      linkUp <= linkEnable & linkOk;  // data path follows the enable
      if (negotiationStart) begin
        pending <= 1'b1;
        waitCnt <= slow ? 4'h9 : 4'h1;
      end else if (pending && waitCnt != 4'h0) begin
        waitCnt <= waitCnt - 4'h1;
      end else if (pending) begin
        pending <= 1'b0;
        pageValid <= 1'b1;
        pageBits <= advert;
      end
    end
  end
endmodule // anrls_partner
`default_nettype wire

// ===== tb/tb_autoneg_resolution_link_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "anrls_map.vh"
module tb_autoneg_resolution_link_status;
  // clock, reset, apb and control
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, roleSelectStrap = 1'b0, highSwingCapable = 1'b1;
  logic [3:0]  advert = 4'hc, pageBits;
  logic        slow = 1'b0, linkOk = 1'b1, pageValid, linkUp, negotiationStart;
  logic        linkEnable, selectedHighSwing, selectedMaster, configFault;
  int          failures = 0, nTests = 0;

  always #2.5 clk = ~clk;

  anrls_autoneg anrls_autoneg_inst (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
    .pready, .pslverr, .roleSelectStrap, .highSwingCapable,
    .partnerPageValid(pageValid), .partnerRoleForcedIn(pageBits[0]),
    .partnerRoleMasterIn(pageBits[1]), .partnerHighSwingOfferIn(pageBits[2]),
    .partnerHighSwingRequestIn(pageBits[3]), .linkUp, .negotiationStart, .linkEnable,
    .selectedHighSwing, .selectedMaster, .configFault
  );
  anrls_partner anrls_partner_inst (
    .clk, .rstn, .negotiationStart, .linkEnable, .advert, .slow, .linkOk,
    .pageValid, .pageBits, .linkUp
  );

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bounded sampling step on the falling edge
  task automatic tick(inout int k);
    @(negedge clk);
    k++;
    if (k > 300) begin
      failures++;
      tally_and_finish();
    end
  endtask

  // apb transfer: setup cycle, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      failures++;
      tally_and_finish();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait for the start pulse, the partner page and the result registered on it
  task automatic awaitResult();
    int k;
    k = 0;
    do tick(k); while (negotiationStart !== 1'b1);
    do tick(k); while (pageValid !== 1'b1);
    tick(k);
  endtask

  // latch-low status: first read shows the loss, second the live link
  task automatic linkReads(input logic [31:0] first);
    repeat (3) @(posedge clk);
    apb(1'b0, `ANRLS_OFS_STATUS, 32'h0);
    check(rd, first);
    apb(1'b0, `ANRLS_OFS_STATUS, 32'h0);
    check(rd, 32'h65);
  endtask

  task automatic testStrap();
    int k;
    for (int s = 1; s >= 0; s--) begin
      rstn <= 1'b0;
      roleSelectStrap <= s[0];
      highSwingCapable <= ~s[0];
      advert <= 4'hc;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, `ANRLS_OFS_LOCAL, 32'h0);
      check(rd, {29'h0, ~s[0], s[0], 1'b0});
      apb(1'b0, 8'h14, 32'h0);
      check({31'h0, pslverr}, 32'h1);
      check(rd, 32'h0);
      k = 0;
      do tick(k); while (linkEnable !== 1'b1);
      apb(1'b0, `ANRLS_OFS_RESULT, 32'h0);
      check(rd & 32'h6, s ? 32'h0 : 32'h4);
      if (s) check(rd & 32'h3, 32'h1);
    end
    $display("strap test done");
  endtask

  task automatic testLinkDrop();
    int k;
    k = 0;
    slow <= 1'b1;
    do tick(k); while (linkUp !== 1'b1);
    repeat (2) @(posedge clk);
    linkOk <= 1'b0;
    do tick(k); while (negotiationStart !== 1'b1);
    check({31'h0, linkEnable}, 32'h0);
    apb(1'b0, `ANRLS_OFS_STATUS, 32'h0);
    check(rd, 32'h1);
    linkOk <= 1'b1;
    k = 0;
    do tick(k); while (linkEnable !== 1'b1);
    linkReads(32'h61);
    $display("link drop test done");
  endtask

  // every local and partner advertisement against each other
  task automatic testSweep();
    logic       fault;
    logic [1:0] role;
    for (int i = 0; i < 256; i++) begin
      fault = i[0] & i[4] & (i[1] == i[5]);
      role = fault ? 2'h2 : i[0] ? {1'b0, i[1]} : i[4] ? {1'b0, ~i[5]} : {1'b0, i[1]};
      slow <= i[0];
      advert <= i[7:4];
      apb(1'b1, `ANRLS_OFS_LOCAL, {28'h0, i[3:0]});
      apb(1'b1, `ANRLS_OFS_CONTROL, 32'h200);
      awaitResult();
      apb(1'b0, `ANRLS_OFS_RESULT, 32'h0);
      if (!i[0] && !i[4] && i[1] == i[5]) role = {1'b0, selectedMaster};
      check({30'h0, rd[1:0]}, {30'h0, role});
      if (!fault) begin
        check({31'h0, rd[2]}, {31'h0, i[2] & i[6] & (i[3] | i[7])});
        apb(1'b0, `ANRLS_OFS_PARTNER, 32'h0);
        check(rd, {28'h0, i[7:4]});
        linkReads(32'h61);
      end else begin
        apb(1'b0, `ANRLS_OFS_STATUS, 32'h0);
        check(rd, 32'h1);
      end
    end
    $display("sweep test done");
  endtask

  initial begin
    testStrap();
    testLinkDrop();
    testSweep();
    tally_and_finish();
  end
endmodule // tb_autoneg_resolution_link_status
`default_nettype wire
